// *** ctc_cfg.svh ***
// Purpose: Constants for the channel trigger control block.
// Assumes: Included by its bare name from the package and the modules.
// Notes: Offsets are byte addresses on the 8-bit parallel bus.
`ifndef CTC_CFG_SVH
`define CTC_CFG_SVH

// ****************************************
// Layout
// ****************************************
`define CTC_NCH 3
`define CTC_CH0_OFS 8'hC0
`define CTC_CH1_OFS 8'hD0
`define CTC_CH2_OFS 8'hE0
`define CTC_CTRL_RST 8'h00
`define CTC_BIT_HSEQ 7
`define CTC_BIT_BEGIN 6
`define CTC_BIT_HBYTE 5
`define CTC_BIT_TP 4
`define CTC_BIT_TE 3
`define CTC_BIT_LRST 2
`define CTC_BIT_TRST 1
`define CTC_BIT_RSVD 0
`define CTC_PTR_W 16
`define CTC_SYNC_FILL 3'h4

`endif

// *** ctc_engine_model.sv ***
// Purpose: Serial engine stand-in that answers start and halt requests per channel.
// Assumes: One sequence per channel at a time; spans are shortened to keep runs brief.
// Notes: A pending halt on an idle channel is answered by a STOP on the next cycle.
`timescale 1ns/1ps
`include "ctc_cfg.svh"

module ctc_engine_model
    import ctc_pkg::*;
#(
    parameter int SPAN = 8
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Requests from the block
    input wire logic [`CTC_NCH-1:0] startReq,
    input wire logic [`CTC_NCH-1:0] haltAfterByte,
    input wire logic [`CTC_NCH-1:0] haltAfterSeq,
    // Status back to the block
    output logic [`CTC_NCH-1:0] chBusy,
    output logic [`CTC_NCH-1:0] stopSeen,
    output logic [`CTC_NCH-1:0] seqEnd
);
    int cnt [`CTC_NCH];

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chBusy <= '0;
            stopSeen <= '0;
            seqEnd <= '0;
            cnt <= '{default: 0};
        end
        else
        begin
            for (int i = 0; i < `CTC_NCH; i++)
            begin
                stopSeen[i] <= 1'b0;
                seqEnd[i] <= 1'b0;
                if (startReq[i])
                begin
                    chBusy[i] <= 1'b1;
                    cnt[i] <= SPAN;
                end
                else if (chBusy[i] && (cnt[i] <= 1 || haltAfterByte[i]))
                begin
                    chBusy[i] <= 1'b0;
                    seqEnd[i] <= !haltAfterByte[i];
                    stopSeen[i] <= haltAfterByte[i] | haltAfterSeq[i];
                end
                else if (chBusy[i])
                    cnt[i] <= cnt[i] - 1;
                else if (haltAfterByte[i] || haltAfterSeq[i])
                    stopSeen[i] <= 1'b1;
            end
        end
    end
endmodule

// *** ctc_pkg.sv ***
// Purpose: Types shared by the channel trigger control modules.
// Assumes: Constants come from the cfg header.
// Notes: The state of ctc_top and of ctc_trig_sync is one packed struct each.
`include "ctc_cfg.svh"

package ctc_pkg;

    typedef struct packed {
        logic tp;
        logic te;
        logic begin_sequence;
        logic halt_after_byte;
        logic halt_after_sequence;
        logic armed;
        logic startReq;
        logic busErr;
        logic lenRst;
        logic tblRst;
        logic [`CTC_PTR_W-1:0] dataPtr;
    } ctc_chan_t;

    typedef struct packed {
        ctc_chan_t [`CTC_NCH-1:0] ch;
        logic [7:0] rdData;
    } ctc_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic tick;
        logic [2:0] fill;
    } ctc_sync_t;

endpackage

// *** ctc_testbench.sv ***
// Purpose: Self-checking bench for the channel control registers and trigger pacing.
// Assumes: Host accesses are one-cycle strobes on mclk.
// Notes: Bit 0 is always written as 0 by every host write here.
`timescale 1ns/1ps

module testbench
    import ctc_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wrData = 8'h00;
    logic wrEn = 1'b0;
    logic rdEn = 1'b0;
    logic [7:0] rdData;
    logic [2:0] trigPin = 3'h1;
    logic [2:0] busFree = 3'h7;
    logic [2:0] chBusy, stopSeen, seqEnd, startReq, busErr, hab, has, tmode, lpr, tpr;
    logic [2:0][7:0] txnSel = '0;
    logic [2:0][7:0] txnOfs = '0;
    logic [2:0][15:0] dataPtr;
    logic [7:0] v;
    logic s;
    int failCount = 0;
    int compares = 0;

    always #5 mclk = ~mclk;

    ctc_top dut_u (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn),
        .rdEn(rdEn), .rdData(rdData), .trigPin(trigPin), .chBusy(chBusy), .busFree(busFree),
        .stopSeen(stopSeen), .seqEnd(seqEnd), .txnSel(txnSel), .txnOfs(txnOfs),
        .startReq(startReq), .busErr(busErr), .haltAfterByte(hab), .haltAfterSeq(has),
        .triggerMode(tmode), .lenPtrReset(lpr), .tablePtrReset(tpr), .dataPtr(dataPtr));

    ctc_engine_model eng_u (.mclk(mclk), .rst_n(rst_n), .startReq(startReq),
        .haltAfterByte(hab), .haltAfterSeq(has), .chBusy(chBusy), .stopSeen(stopSeen),
        .seqEnd(seqEnd));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failCount++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wrData <= d & 8'hFE;
        wrEn <= 1'b1;
        @(posedge mclk);
        wrEn <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge mclk);
        rdEn <= 1'b0;
        #1;
        d = rdData;
    endtask

    // Watches a channel's start request for a bounded span.
    task automatic waitStart(input int ch, output logic seen);
        seen = 1'b0;
        repeat (10)
        begin
            @(posedge mclk);
            #1;
            if (startReq[ch] === 1'b1)
                seen = 1'b1;
        end
    endtask

    task automatic results;
        $display("compares %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'hC0, v);
        check(16'(v), 16'h0000);
        rd(8'hC1, v);
        check(16'(v), 16'h0000);
        $display("test reset done");
        wr(8'hC0, 8'h1C);
        check(16'(lpr), 16'h0001);
        check(16'(tpr), 16'h0000);
        rd(8'hC0, v);
        check(16'(v), 16'h0018);
        txnSel[1] <= 8'h12;
        txnOfs[1] <= 8'h34;
        wr(8'hD0, 8'h02);
        check(16'(tpr), 16'h0002);
        check(dataPtr[1], 16'h1234);
        rd(8'hD0, v);
        check(16'(v), 16'h0000);
        txnSel[1] <= 8'h00;
        wr(8'hD0, 8'h02);
        check(dataPtr[1], 16'h0034);
        wr(8'hC0, 8'hB8);
        check(16'(hab), 16'h0000);
        rd(8'hC0, v);
        check(16'(v), 16'h0018);
        $display("test fields done");
        @(posedge mclk);
        trigPin[0] <= 1'b0;
        repeat (2) @(posedge mclk);
        wr(8'hC0, 8'h58);
        check(16'(tmode), 16'h0001);
        waitStart(0, s);
        check(16'(s), 16'h0000);
        trigPin[0] <= 1'b1;
        waitStart(0, s);
        check(16'(s), 16'h0000);
        trigPin[0] <= 1'b0;
        waitStart(0, s);
        check(16'(s), 16'h0001);
        wr(8'hC0, 8'h40);
        rd(8'hC0, v);
        check(16'(v), 16'h0058);
        wr(8'hC0, 8'hF8);
        check(16'(hab), 16'h0001);
        check(16'(has), 16'h0000);
        repeat (12) @(posedge mclk);
        rd(8'hC0, v);
        check(16'(v), 16'h0018);
        $display("test trigger done");
        busFree[2] <= 1'b0;
        wr(8'hE0, 8'h40);
        check(16'(busErr), 16'h0004);
        check(16'(startReq), 16'h0000);
        busFree[2] <= 1'b1;
        wr(8'hE0, 8'h40);
        check(16'(startReq), 16'h0004);
        trigPin[2] <= 1'b1;
        waitStart(2, s);
        check(16'(s), 16'h0000);
        $display("test plain start done");
        results();
    end

    initial
    begin
        #20000;
        failCount++;
        results();
    end
endmodule

// *** ctc_top.sv ***
// Purpose: Per-channel control registers and trigger pacing of a 3-channel serial controller.
// Assumes: Host uses a synchronous 8-bit bus on mclk; the serial engine is on mclk.
// Notes: Reads return data one cycle after the read strobe.
`timescale 1ns/1ps
`include "ctc_cfg.svh"

module ctc_top
    import ctc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Host parallel bus
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [7:0] rdData,
    // Trigger pins
    input wire logic [`CTC_NCH-1:0] trigPin,
    // Status from the serial engine
    input wire logic [`CTC_NCH-1:0] chBusy,
    input wire logic [`CTC_NCH-1:0] busFree,
    input wire logic [`CTC_NCH-1:0] stopSeen,
    input wire logic [`CTC_NCH-1:0] seqEnd,
    // Transaction position per channel
    input wire logic [`CTC_NCH-1:0][7:0] txnSel,
    input wire logic [`CTC_NCH-1:0][7:0] txnOfs,
    // Requests to the serial engine
    output logic [`CTC_NCH-1:0] startReq,
    output logic [`CTC_NCH-1:0] busErr,
    output logic [`CTC_NCH-1:0] haltAfterByte,
    output logic [`CTC_NCH-1:0] haltAfterSeq,
    output logic [`CTC_NCH-1:0] triggerMode,
    // Pointer control
    output logic [`CTC_NCH-1:0] lenPtrReset,
    output logic [`CTC_NCH-1:0] tablePtrReset,
    output logic [`CTC_NCH-1:0][`CTC_PTR_W-1:0] dataPtr
);

    ctc_state_t q;
    ctc_state_t d;
    logic [`CTC_NCH-1:0] tick;

    // ****************************************
    // Address decode
    // ****************************************
    // Returns a hit flag above a two-bit channel index.
    function automatic logic [2:0] decodeChan(input logic [7:0] a);
        logic [2:0] r;
        r = 3'h0;
        unique case (a)
            `CTC_CH0_OFS: r = 3'h4;
            `CTC_CH1_OFS: r = 3'h5;
            `CTC_CH2_OFS: r = 3'h6;
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    // ****************************************
    // Trigger synchronisers
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `CTC_NCH; g++)
        begin : gSync
            ctc_trig_if tif ();
            assign tif.polarity = q.ch[g].tp;
            assign tick[g] = tif.tick;
            ctc_trig_sync uSync (
                .mclk(mclk),
                .rst_n(rst_n),
                .trigPin(trigPin[g]),
                .trig(tif)
            );
        end
    endgenerate

    // ****************************************
    // Register and sequencing logic
    // ****************************************
    always_comb
    begin
        logic act;
        logic hit;
        logic [2:0] wsel;
        logic [2:0] rsel;
        act = 1'b0;
        hit = 1'b0;
        wsel = decodeChan(addr);
        rsel = wsel;
        d = q;
        d.rdData = 8'h00;
        for (int i = 0; i < `CTC_NCH; i++)
        begin
            act = q.ch[i].begin_sequence | chBusy[i];
            hit = wrEn && wsel[2] && (wsel[1:0] == 2'(i));
            d.ch[i].startReq = 1'b0;
            d.ch[i].busErr = 1'b0;
            d.ch[i].lenRst = 1'b0;
            d.ch[i].tblRst = 1'b0;
            // Arming lags the begin bit by a cycle, so a coincident tick is lost.
            d.ch[i].armed = q.ch[i].begin_sequence & q.ch[i].te;
            if (stopSeen[i])
            begin
                // A seen STOP ends the channel and drops both halt requests.
                d.ch[i].halt_after_byte = 1'b0;
                d.ch[i].halt_after_sequence = 1'b0;
                d.ch[i].begin_sequence = 1'b0;
            end
            // In trigger mode the loop count never ends the sequence.
            if (seqEnd[i] && !q.ch[i].te)
                d.ch[i].begin_sequence = 1'b0;
            // Ticks only count when enabled, armed and no halt is pending.
            if (tick[i] && q.ch[i].te && q.ch[i].armed && q.ch[i].begin_sequence &&
                !q.ch[i].halt_after_byte && !q.ch[i].halt_after_sequence)
                d.ch[i].startReq = 1'b1;
            if (hit)
            begin
                if (!act)
                begin
                    d.ch[i].tp = wrData[`CTC_BIT_TP];
                    d.ch[i].te = wrData[`CTC_BIT_TE];
                    if (wrData[`CTC_BIT_BEGIN])
                    begin
                        if (busFree[i])
                        begin
                            d.ch[i].begin_sequence = 1'b1;
                            // Without trigger mode the START goes out at once.
                            d.ch[i].startReq = !wrData[`CTC_BIT_TE];
                        end
                        else
                            d.ch[i].busErr = 1'b1;
                    end
                end
                // Halt requests only land on a running channel; set beats clear.
                if (q.ch[i].begin_sequence)
                begin
                    d.ch[i].halt_after_byte = d.ch[i].halt_after_byte | wrData[`CTC_BIT_HBYTE];
                    d.ch[i].halt_after_sequence = d.ch[i].halt_after_sequence | wrData[`CTC_BIT_HSEQ];
                end
                d.ch[i].lenRst = wrData[`CTC_BIT_LRST];
                d.ch[i].tblRst = wrData[`CTC_BIT_TRST];
                if (wrData[`CTC_BIT_TRST])
                    d.ch[i].dataPtr = {txnSel[i], txnOfs[i]};
            end
            if (rdEn && rsel[2] && (rsel[1:0] == 2'(i)))
            begin
                // Pulse bits and the reserved bit always read as zero.
                d.rdData = `CTC_CTRL_RST;
                d.rdData[`CTC_BIT_HSEQ] = q.ch[i].halt_after_sequence;
                d.rdData[`CTC_BIT_BEGIN] = q.ch[i].begin_sequence;
                d.rdData[`CTC_BIT_HBYTE] = q.ch[i].halt_after_byte;
                d.rdData[`CTC_BIT_TP] = q.ch[i].tp;
                d.rdData[`CTC_BIT_TE] = q.ch[i].te;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    // ****************************************
    // Outputs and checks
    // ****************************************
    assign rdData = q.rdData;

    generate
        for (g = 0; g < `CTC_NCH; g++)
        begin : gOut
            assign startReq[g] = q.ch[g].startReq;
            assign busErr[g] = q.ch[g].busErr;
            assign haltAfterByte[g] = q.ch[g].halt_after_byte;
            // The byte-level halt masks the sequence-level one.
            assign haltAfterSeq[g] = q.ch[g].halt_after_sequence & ~q.ch[g].halt_after_byte;
            assign triggerMode[g] = q.ch[g].te;
            assign lenPtrReset[g] = q.ch[g].lenRst;
            assign tablePtrReset[g] = q.ch[g].tblRst;
            assign dataPtr[g] = q.ch[g].dataPtr;

            a_tp_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
                (q.ch[g].begin_sequence || chBusy[g]) |=> $stable(q.ch[g].tp))
                else $error("polarity changed while active");
            a_te_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
                (q.ch[g].begin_sequence || chBusy[g]) |=> $stable(q.ch[g].te))
                else $error("trigger enable changed while active");
            a_te_ignore: assert property (@(posedge mclk) disable iff (!rst_n)
                (!q.ch[g].te && !wrEn) |=> !q.ch[g].startReq)
                else $error("start while trigger disabled without a write");
            a_arm_delay: assert property (@(posedge mclk) disable iff (!rst_n)
                ($rose(q.ch[g].begin_sequence) && q.ch[g].te) |-> !q.ch[g].startReq ##1
                !q.ch[g].startReq)
                else $error("trigger start too soon after begin");
            // Back-to-back writes may legally keep the pulse up for a second cycle.
            a_len_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
                (wrEn && decodeChan(addr) == {1'b1, 2'(g)} && wrData[`CTC_BIT_LRST])
                |=> lenPtrReset[g] ##1
                (!lenPtrReset[g] || $past(wrEn && wrData[`CTC_BIT_LRST])))
                else $error("length pointer reset pulse wrong");
            a_tbl_load: assert property (@(posedge mclk) disable iff (!rst_n)
                (wrEn && decodeChan(addr) == {1'b1, 2'(g)} && wrData[`CTC_BIT_TRST])
                |=> tablePtrReset[g] && dataPtr[g] == {$past(txnSel[g]), $past(txnOfs[g])})
                else $error("table reset or data pointer load wrong");
            a_halt_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
                (!q.ch[g].begin_sequence && !q.ch[g].halt_after_byte) |=> !q.ch[g].halt_after_byte)
                else $error("halt set while not begun");
            a_halt_prio: assert property (@(posedge mclk) disable iff (!rst_n)
                !(haltAfterSeq[g] && haltAfterByte[g]))
                else $error("both halt requests asserted");
            a_bus_err: assert property (@(posedge mclk) disable iff (!rst_n)
                (wrEn && decodeChan(addr) == {1'b1, 2'(g)} && wrData[`CTC_BIT_BEGIN]
                && !q.ch[g].begin_sequence && !chBusy[g] && !busFree[g])
                |=> busErr[g] && !q.ch[g].begin_sequence)
                else $error("busy bus not reported");
            a_stop_clear: assert property (@(posedge mclk) disable iff (!rst_n)
                (stopSeen[g] && !wrEn) |=> !q.ch[g].halt_after_sequence && !q.ch[g].begin_sequence)
                else $error("halt not cleared on stop");
        end
    endgenerate

    a_rd_pulse_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        rdData[2:0] == 3'h0)
        else $error("pulse or reserved bits read nonzero");

endmodule

// *** ctc_trig_if.sv ***
// Purpose: Carries polarity to a trigger synchroniser and its tick back.
// Assumes: One instance per channel.
// Notes: Tick is a one-cycle pulse on mclk.
`timescale 1ns/1ps

interface ctc_trig_if;
    logic polarity;
    logic tick;
    modport sync (input polarity, output tick);
    modport ctrl (output polarity, input tick);
endinterface

// *** ctc_trig_sync.sv ***
// Purpose: Synchronise one trigger pin and detect edges of one polarity.
// Assumes: Pin is asynchronous to mclk.
// Notes: A change counts once the second and third flops agree.
`timescale 1ns/1ps
`include "ctc_cfg.svh"

module ctc_trig_sync
    import ctc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pin
    input wire logic trigPin,
    // Tick toward the control logic
    ctc_trig_if.sync trig
);

    ctc_sync_t q;
    ctc_sync_t d;

    // ****************************************
    // Edge detection
    // ****************************************
    always_comb
    begin
        d = q;
        d.s1 = trigPin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.tick = 1'b0;
        // Ticks wait until the flops hold the real pin level, so a pin resting high
        // through reset is not taken for a rising edge.
        if (q.fill != `CTC_SYNC_FILL)
            d.fill = 3'(q.fill + 3'h1);
        if (q.s2 == q.s3)
        begin
            d.lvl = q.s3;
            // A rising edge ends high with polarity 0, a falling one low with 1.
            d.tick = (q.fill == `CTC_SYNC_FILL) && (q.s3 != q.lvl) &&
                (q.s3 != trig.polarity);
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    assign trig.tick = q.tick;

    a_tick_single: assert property (@(posedge mclk) disable iff (!rst_n)
        trig.tick |=> !trig.tick) else $error("trigger tick longer than one cycle");

endmodule
